// [rtl/sfsp_device.sv]
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module sfsp_device #(
    parameter int P_WRITE_CYC = sfsp_pkg::STATUS_WRITE_CYC,
    parameter int P_OP_CYC = sfsp_pkg::ARRAY_OP_CYC
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    sfsp_link_if.device link,
    output logic [7:0] o_status,
    output logic o_hard_lock_mode,
    output logic o_soft_lock_mode,
    output logic o_array_op,
    output logic [7:0] o_array_kind,
    output logic [23:0] o_array_addr
);
    // ==================================================================
    // state
    typedef struct packed {
        logic sclk_prev;
        logic cs_prev;
        sfsp_pkg::sfsp_dev_phase_t phase;
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] shift;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] wdata;
        logic [2:0] out_cnt;
        logic [7:0] out_sh;
        logic sout;
        logic busy;
        logic [15:0] busy_cnt;
        logic busy_is_wr;
        logic write_latch_flag;
        logic lock;
        logic [2:0] guard;
        logic op_pulse;
        logic [7:0] op_kind;
        logic [23:0] op_addr;
    } sfsp_dev_state_t;

    sfsp_dev_state_t s_r;
    sfsp_dev_state_t s_nxt;
    logic [3:0] pins_sync;
    logic cs_n_s;
    logic sclk_s;
    logic sin_s;
    logic guard_n_s;

    if (P_WRITE_CYC < 1 || P_WRITE_CYC > 65535 ||
        P_OP_CYC < 1 || P_OP_CYC > 65535) begin : g_chk
        $error("sfsp_device: cycle counts must be 1..65535");
    end

    // ==================================================================
    // pin synchronisers
    sfsp_sync #(.WIDTH(4)) u_sync (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_async({link.cs_n, link.sclk, link.serial_in, link.guard_n}),
        .o_sync(pins_sync)
    );
    assign {cs_n_s, sclk_s, sin_s, guard_n_s} = pins_sync;

    // ==================================================================
    // helpers
    function automatic logic [7:0] status_of(sfsp_dev_state_t st);
        logic [7:0] w;
        w = 8'h00;
        w[sfsp_pkg::BUSY_POS] = st.busy;
        w[sfsp_pkg::LATCH_POS] = st.write_latch_flag;
        w[sfsp_pkg::GUARD_LO +: 3] = st.guard;
        w[sfsp_pkg::LOCK_POS] = st.lock;
        return w & sfsp_pkg::STATUS_RD_MASK;
    endfunction : status_of

    // guarded sectors grow from the top: 1, 2, 4 ... sectors
    function automatic logic area_guarded(logic [2:0] g, logic [23:0] a);
        logic [7:0] cnt;
        logic [7:0] sector;
        cnt = 8'h00;
        sector = {4'h0, a[sfsp_pkg::SECTOR_LO +: 4]};
        if (g != 3'h0) begin
            cnt = 8'h01 << (g - 3'h1);
        end
        if (cnt > sfsp_pkg::SECTOR_COUNT) begin
            cnt = sfsp_pkg::SECTOR_COUNT;
        end
        return (cnt != 8'h00) &&
            (sector >= sfsp_pkg::SECTOR_COUNT - cnt);
    endfunction : area_guarded

    // ==================================================================
    // next state
    always_comb begin
        logic rise;
        logic fall;
        logic sel_end;
        logic hard;
        logic accept;
        logic [7:0] in_byte;
        logic [7:0] nv;
        int cyc;
        rise = 1'b0;
        fall = 1'b0;
        sel_end = 1'b0;
        hard = 1'b0;
        accept = 1'b0;
        in_byte = 8'h00;
        nv = 8'h00;
        cyc = 0;
        s_nxt = s_r;
        s_nxt.sclk_prev = sclk_s;
        s_nxt.cs_prev = cs_n_s;
        s_nxt.op_pulse = 1'b0;
        rise = sclk_s & ~s_r.sclk_prev & ~cs_n_s;
        fall = ~sclk_s & s_r.sclk_prev & ~cs_n_s;
        sel_end = cs_n_s & ~s_r.cs_prev;
        hard = s_r.lock & ~guard_n_s;
        in_byte = {s_r.shift[6:0], sin_s};

        // self-timed cycle
        if (s_r.busy) begin
            if (s_r.busy_cnt == 16'h0000) begin
                s_nxt.busy = 1'b0;
                s_nxt.write_latch_flag = 1'b0;
                if (s_r.busy_is_wr) begin
                    nv = s_r.wdata & sfsp_pkg::STATUS_WR_MASK;
                    s_nxt.lock = nv[sfsp_pkg::LOCK_POS];
                    s_nxt.guard = nv[sfsp_pkg::GUARD_LO +: 3];
                end
            end else begin
                s_nxt.busy_cnt = s_r.busy_cnt - 16'h0001;
            end
        end

        // serial framing
        if (cs_n_s) begin
            s_nxt.phase = sfsp_pkg::DEV_IDLE;
            s_nxt.bit_cnt = 3'h0;
            s_nxt.byte_cnt = 3'h0;
            s_nxt.out_cnt = 3'h0;
            s_nxt.sout = 1'b0;
        end else if (s_r.phase == sfsp_pkg::DEV_IDLE) begin
            s_nxt.phase = sfsp_pkg::DEV_CMD;
        end else if (rise && (s_r.phase == sfsp_pkg::DEV_CMD ||
                              s_r.phase == sfsp_pkg::DEV_ARG)) begin
            s_nxt.shift = in_byte;
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == 3'h7) begin
                if (s_r.byte_cnt != 3'h7) begin
                    s_nxt.byte_cnt = s_r.byte_cnt + 3'h1;
                end
                case (s_r.phase)
                    sfsp_pkg::DEV_CMD: begin
                        s_nxt.opcode = in_byte;
                        if (in_byte == sfsp_pkg::CMD_READ_STATUS) begin
                            s_nxt.phase = sfsp_pkg::DEV_OUT;
                            s_nxt.out_sh = status_of(s_r);
                        end else begin
                            s_nxt.phase = sfsp_pkg::DEV_ARG;
                        end
                    end
                    default: begin
                        if (s_r.byte_cnt <= 3'h3) begin
                            s_nxt.addr = {s_r.addr[15:0], in_byte};
                        end
                        if (s_r.byte_cnt == 3'h1) begin
                            s_nxt.wdata = in_byte;
                        end
                    end
                endcase
            end
        end else if (fall && s_r.phase == sfsp_pkg::DEV_OUT) begin
            s_nxt.sout = s_r.out_sh[7];
            s_nxt.out_cnt = s_r.out_cnt + 3'h1;
            if (s_r.out_cnt == 3'h7) begin
                s_nxt.out_sh = status_of(s_r);
            end else begin
                s_nxt.out_sh = {s_r.out_sh[6:0], 1'b0};
            end
        end

        // command execution at deselect, on a byte boundary only
        if (sel_end && s_r.phase == sfsp_pkg::DEV_ARG &&
            s_r.bit_cnt == 3'h0 && !s_r.busy) begin
            case (s_r.opcode)
                sfsp_pkg::CMD_WR_ENABLE: begin
                    if (s_r.byte_cnt == sfsp_pkg::LEN_SHORT) begin
                        s_nxt.write_latch_flag = 1'b1;
                    end
                end
                sfsp_pkg::CMD_WR_DISABLE: begin
                    if (s_r.byte_cnt == sfsp_pkg::LEN_SHORT) begin
                        s_nxt.write_latch_flag = 1'b0;
                    end
                end
                sfsp_pkg::CMD_WRITE_STATUS: begin
                    accept = s_r.byte_cnt == sfsp_pkg::LEN_STATUS &&
                        s_r.write_latch_flag && !hard;
                    cyc = P_WRITE_CYC;
                end
                sfsp_pkg::CMD_PAGE_PROG: begin
                    accept = s_r.byte_cnt >= sfsp_pkg::LEN_PROG &&
                        s_r.write_latch_flag &&
                        !area_guarded(s_r.guard, s_r.addr);
                    cyc = P_OP_CYC;
                end
                sfsp_pkg::CMD_SECTOR_ERASE: begin
                    accept = s_r.byte_cnt == sfsp_pkg::LEN_ERASE &&
                        s_r.write_latch_flag &&
                        !area_guarded(s_r.guard, s_r.addr);
                    cyc = P_OP_CYC;
                end
                sfsp_pkg::CMD_BULK_ERASE: begin
                    accept = s_r.byte_cnt == sfsp_pkg::LEN_SHORT &&
                        s_r.write_latch_flag && s_r.guard == 3'h0;
                    cyc = P_OP_CYC;
                end
                default: begin
                    accept = 1'b0;
                end
            endcase
            if (accept) begin
                s_nxt.busy = 1'b1;
                s_nxt.busy_cnt = 16'(cyc - 1);
                s_nxt.busy_is_wr =
                    s_r.opcode == sfsp_pkg::CMD_WRITE_STATUS;
                s_nxt.op_pulse =
                    s_r.opcode != sfsp_pkg::CMD_WRITE_STATUS;
                s_nxt.op_kind = s_r.opcode;
                s_nxt.op_addr = s_r.addr;
            end
        end
    end

    // ==================================================================
    // registers
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '0;
            s_r.phase <= sfsp_pkg::DEV_IDLE;
            s_r.sclk_prev <= 1'b0;
            s_r.cs_prev <= 1'b1;
            s_r.lock <= sfsp_pkg::LOCK_RESET;
            s_r.guard <= sfsp_pkg::GUARD_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==================================================================
    // outputs
    assign link.serial_out = s_r.sout;
    assign o_status = status_of(s_r);
    assign o_hard_lock_mode = s_r.lock & ~guard_n_s;
    assign o_soft_lock_mode = s_r.guard != 3'h0;
    assign o_array_op = s_r.op_pulse;
    assign o_array_kind = s_r.op_kind;
    assign o_array_addr = s_r.op_addr;
endmodule : sfsp_device

// [rtl/sfsp_pkg.sv]
package sfsp_pkg;
    // ==================================================================
    // command codes
    localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'hd8;
    localparam logic [7:0] CMD_BULK_ERASE = 8'hc7;
    // ==================================================================
    // status word layout
    localparam int BUSY_POS = 0;
    localparam int LATCH_POS = 1;
    localparam int GUARD_LO = 2;
    localparam int LOCK_POS = 7;
    localparam logic [7:0] STATUS_WR_MASK = 8'h8c;
    localparam logic [7:0] STATUS_RD_MASK = 8'h8f;
    localparam logic [2:0] GUARD_RESET = 3'h0;
    localparam logic LOCK_RESET = 1'b0;
    localparam int SECTOR_LO = 16;
    localparam logic [7:0] SECTOR_COUNT = 8'h10;
    // byte counts of accepted frames, opcode included
    localparam logic [2:0] LEN_SHORT = 3'h1;
    localparam logic [2:0] LEN_STATUS = 3'h2;
    localparam logic [2:0] LEN_ERASE = 3'h4;
    localparam logic [2:0] LEN_PROG = 3'h5;
    // ==================================================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int STATUS_WRITE_TIME_NS = 10000;
    localparam int STATUS_WRITE_CYC =
        (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ARRAY_OP_TIME_NS = 20000;
    localparam int ARRAY_OP_CYC =
        (ARRAY_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LINK_HALF_DIV = 5;
    // ==================================================================
    // host register map
    localparam logic [31:0] REG_CMD = 32'h0000_0000;
    localparam logic [31:0] REG_TXDATA = 32'h0000_0004;
    localparam logic [31:0] REG_STAT = 32'h0000_0008;
    localparam logic [31:0] REG_GUARD = 32'h0000_000c;
    localparam int CMD_TX_LO = 8;
    localparam int CMD_RX_LO = 11;
    localparam int STAT_RX_LO = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==================================================================
    // states
    typedef enum logic [3:0] {
        DEV_IDLE = 4'h1,
        DEV_CMD = 4'h2,
        DEV_ARG = 4'h4,
        DEV_OUT = 4'h8
    } sfsp_dev_phase_t;
    typedef enum logic [4:0] {
        HST_IDLE = 5'h01,
        HST_LOW = 5'h02,
        HST_HIGH = 5'h04,
        HST_END = 5'h08,
        HST_GAP = 5'h10
    } sfsp_hst_state_t;
endpackage : sfsp_pkg

// [rtl/sfsp_link_if.sv]
`timescale 1ns/1ps
interface sfsp_link_if;
    logic cs_n;
    logic sclk;
    logic serial_in;
    logic serial_out;
    logic guard_n;
    modport device (input cs_n, input sclk, input serial_in,
        input guard_n, output serial_out);
    modport host (output cs_n, output sclk, output serial_in,
        output guard_n, input serial_out);
endinterface : sfsp_link_if

// [rtl/sfsp_sync.sv]
`timescale 1ns/1ps
module sfsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sfsp_sync_state_t;

    sfsp_sync_state_t s_r;
    sfsp_sync_state_t s_nxt;

    if (WIDTH < 1) begin : g_chk
        $error("sfsp_sync: WIDTH must be at least 1");
    end

    always_comb begin
        s_nxt.stage1 = i_async;
        s_nxt.stage2 = s_r.stage1;
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_sync = s_r.stage2;
endmodule : sfsp_sync

// [rtl/sfsp_host.sv]
`timescale 1ns/1ps
module sfsp_host #(
    parameter int P_HALF_DIV = sfsp_pkg::LINK_HALF_DIV
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    sfsp_link_if.host link,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [31:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);
    // ==================================================================
    // state
    typedef struct packed {
        sfsp_pkg::sfsp_hst_state_t state;
        logic [7:0] div;
        logic [6:0] bits_left;
        logic [39:0] tx_sh;
        logic [7:0] rx_sh;
        logic cs_n;
        logic sclk;
        logic guard_n;
        logic [31:0] txdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sfsp_hst_reg_t;

    sfsp_hst_reg_t s_r;
    sfsp_hst_reg_t s_nxt;
    logic sout_s;
    logic wr_take;
    logic rd_take;

    if (P_HALF_DIV < 4 || P_HALF_DIV > 255) begin : g_chk
        $error("sfsp_host: P_HALF_DIV must be 4..255");
    end

    sfsp_sync #(.WIDTH(1)) u_sync (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_async(link.serial_out),
        .o_sync(sout_s)
    );

    assign o_awready = i_awvalid & i_wvalid & ~s_r.bvalid;
    assign o_wready = o_awready;
    assign o_arready = ~s_r.rvalid;
    assign wr_take = o_awready;
    assign rd_take = i_arvalid & ~s_r.rvalid;

    // ==================================================================
    // next state
    always_comb begin
        logic half_done;
        logic [3:0] nbytes;
        half_done = 1'b0;
        nbytes = 4'h0;
        s_nxt = s_r;
        half_done = s_r.div == 8'(P_HALF_DIV - 1);
        s_nxt.div = half_done ? 8'h00 : s_r.div + 8'h01;
        if (s_r.bvalid && i_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && i_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // register writes
        if (wr_take) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = sfsp_pkg::RESP_OKAY;
            case (i_awaddr)
                sfsp_pkg::REG_CMD: begin
                    if (s_r.state == sfsp_pkg::HST_IDLE && i_wstrb[0]) begin
                        nbytes = {1'b0, i_wdata[sfsp_pkg::CMD_TX_LO +: 3]}
                            + {1'b0, i_wdata[sfsp_pkg::CMD_RX_LO +: 3]}
                            + 4'h1;
                        s_nxt.state = sfsp_pkg::HST_LOW;
                        s_nxt.div = 8'h00;
                        s_nxt.cs_n = 1'b0;
                        s_nxt.sclk = 1'b0;
                        s_nxt.bits_left = {nbytes, 3'h0};
                        s_nxt.tx_sh = {i_wdata[7:0], s_r.txdata};
                    end
                end
                sfsp_pkg::REG_TXDATA: begin
                    for (int i = 0; i < 4; i++) begin
                        if (i_wstrb[i]) begin
                            s_nxt.txdata[i*8 +: 8] = i_wdata[i*8 +: 8];
                        end
                    end
                end
                sfsp_pkg::REG_GUARD: begin
                    if (i_wstrb[0]) begin
                        s_nxt.guard_n = i_wdata[0];
                    end
                end
                sfsp_pkg::REG_STAT: begin
                    s_nxt.bresp = sfsp_pkg::RESP_OKAY;
                end
                default: begin
                    s_nxt.bresp = sfsp_pkg::RESP_SLVERR;
                end
            endcase
        end

        // register reads
        if (rd_take) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = sfsp_pkg::RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            case (i_araddr)
                sfsp_pkg::REG_TXDATA: s_nxt.rdata = s_r.txdata;
                sfsp_pkg::REG_STAT: begin
                    s_nxt.rdata[0] = s_r.state != sfsp_pkg::HST_IDLE;
                    s_nxt.rdata[sfsp_pkg::STAT_RX_LO +: 8] = s_r.rx_sh;
                end
                sfsp_pkg::REG_GUARD: s_nxt.rdata[0] = s_r.guard_n;
                sfsp_pkg::REG_CMD: s_nxt.rdata = 32'h0000_0000;
                default: s_nxt.rresp = sfsp_pkg::RESP_SLVERR;
            endcase
        end

        // serial engine, mode 0
        case (s_r.state)
            sfsp_pkg::HST_IDLE: begin
                s_nxt.div = 8'h00;
            end
            sfsp_pkg::HST_LOW: begin
                if (half_done) begin
                    s_nxt.sclk = 1'b1;
                    s_nxt.state = sfsp_pkg::HST_HIGH;
                end
            end
            sfsp_pkg::HST_HIGH: begin
                if (half_done) begin
                    s_nxt.sclk = 1'b0;
                    s_nxt.rx_sh = {s_r.rx_sh[6:0], sout_s};
                    s_nxt.bits_left = s_r.bits_left - 7'h01;
                    s_nxt.tx_sh = {s_r.tx_sh[38:0], 1'b0};
                    if (s_r.bits_left == 7'h01) begin
                        s_nxt.state = sfsp_pkg::HST_END;
                    end else begin
                        s_nxt.state = sfsp_pkg::HST_LOW;
                    end
                end
            end
            sfsp_pkg::HST_END: begin
                if (half_done) begin
                    s_nxt.cs_n = 1'b1;
                    s_nxt.state = sfsp_pkg::HST_GAP;
                end
            end
            sfsp_pkg::HST_GAP: begin
                if (half_done) begin
                    s_nxt.state = sfsp_pkg::HST_IDLE;
                end
            end
            default: begin
                s_nxt.state = sfsp_pkg::HST_IDLE;
                s_nxt.cs_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '0;
            s_r.state <= sfsp_pkg::HST_IDLE;
            s_r.cs_n <= 1'b1;
            s_r.guard_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==================================================================
    // outputs
    assign link.cs_n = s_r.cs_n;
    assign link.sclk = s_r.sclk;
    assign link.serial_in = s_r.tx_sh[39];
    assign link.guard_n = s_r.guard_n;
    assign o_bvalid = s_r.bvalid;
    assign o_bresp = s_r.bresp;
    assign o_rvalid = s_r.rvalid;
    assign o_rdata = s_r.rdata;
    assign o_rresp = s_r.rresp;
endmodule : sfsp_host

// [verif/sfsp_props.sv]
`timescale 1ns/1ps
module sfsp_props (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic guard_n,
    input wire logic [7:0] o_status,
    input wire logic o_hard_lock_mode
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // ==================================================================
    // sequences
    sequence s_locked; (o_status[7] && !guard_n) [*4]; endsequence
    sequence s_free; guard_n [*4]; endsequence
    // ==================================================================
    // properties
    property p_zero_bits; o_status[6:4] == 3'h0; endproperty
    property p_enter; s_locked |-> o_hard_lock_mode; endproperty
    property p_leave; s_free |-> !o_hard_lock_mode; endproperty
    property p_start; $rose(o_status[0]) |-> cs_n && $past(o_status[1]);
    endproperty
    property p_hold; $rose(o_status[0]) |=> o_status[0] [*8]; endproperty
    property p_latch; $fell(o_status[0]) |-> !o_status[1]; endproperty
    property p_nv; $changed(o_status[7:2]) |-> $fell(o_status[0]);
    endproperty
    property p_frozen; $changed(o_status[7:2]) |-> !$past(o_hard_lock_mode);
    endproperty
    property p_idle; cs_n |-> !sclk; endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("status high bits not zero");
    a_enter: assert property (p_enter)
        else $error("hard lock not entered");
    a_leave: assert property (p_leave)
        else $error("hard lock not left");
    a_start: assert property (p_start)
        else $error("busy rose without deselect or latch");
    a_hold: assert property (p_hold)
        else $error("busy dropped early");
    a_latch: assert property (p_latch)
        else $error("latch kept after cycle");
    a_nv: assert property (p_nv)
        else $error("guard or lock changed outside cycle end");
    a_frozen: assert property (p_frozen)
        else $error("status changed in hard lock");
    a_idle: assert property (p_idle)
        else $error("serial clock moved while deselected");
endmodule : sfsp_props

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic aw = 1'b0, ar = 1'b0, hl, awr, wr_r, arr, bv, rv;
    logic [31:0] aa = 32'h0, wd = 32'h0, ra = 32'h0, rdat;
    logic [1:0] br, rr;
    logic [7:0] st, s;
    logic sl, op;
    logic [7:0] okind;
    logic [23:0] oaddr;
    int ops = 0;
    int err_count = 0;
    int checks = 0;
    always #4 i_mclk = ~i_mclk;
    // counts accepted program and erase operations
    always @(posedge i_mclk) if (op) ops <= ops + 1;
    sfsp_link_if sfsp_link_if_inst ();
    sfsp_device #(.P_WRITE_CYC(400), .P_OP_CYC(20)) sfsp_device_inst (
        .i_mclk(i_mclk), .i_reset(i_reset), .link(sfsp_link_if_inst),
        .o_status(st), .o_hard_lock_mode(hl), .o_soft_lock_mode(sl),
        .o_array_op(op), .o_array_kind(okind), .o_array_addr(oaddr));
    sfsp_host sfsp_host_inst (.i_mclk(i_mclk), .i_reset(i_reset),
        .link(sfsp_link_if_inst), .i_awvalid(aw), .o_awready(awr),
        .i_awaddr(aa), .i_wvalid(aw), .o_wready(wr_r), .i_wdata(wd),
        .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(1'b1), .o_bresp(br),
        .i_arvalid(ar), .o_arready(arr), .i_araddr(ra), .o_rvalid(rv),
        .i_rready(1'b1), .o_rdata(rdat), .o_rresp(rr));
    sfsp_props sfsp_props_inst (.i_mclk(i_mclk), .i_reset(i_reset),
        .cs_n(sfsp_link_if_inst.cs_n), .sclk(sfsp_link_if_inst.sclk),
        .guard_n(sfsp_link_if_inst.guard_n), .o_status(st),
        .o_hard_lock_mode(hl));
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, d, input logic [1:0] e);
        @(posedge i_mclk); aw <= 1'b1; aa <= a; wd <= d;
        #1 while (!(awr && wr_r)) begin @(posedge i_mclk); #1; end
        @(posedge i_mclk); aw <= 1'b0;
        #1 while (!bv) begin @(posedge i_mclk); #1; end
        chk(br, e);
        @(posedge i_mclk);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [1:0] e,
        output logic [31:0] d);
        @(posedge i_mclk); ar <= 1'b1; ra <= a;
        #1 while (!arr) begin @(posedge i_mclk); #1; end
        @(posedge i_mclk); ar <= 1'b0;
        #1 while (!rv) begin @(posedge i_mclk); #1; end
        chk(rr, e);
        d = rdat;
        @(posedge i_mclk);
    endtask : rd
    task automatic frame(input logic [31:0] c, t);
        logic [31:0] d;
        wr(sfsp_pkg::REG_TXDATA, t, sfsp_pkg::RESP_OKAY);
        wr(sfsp_pkg::REG_CMD, c, sfsp_pkg::RESP_OKAY);
        do rd(sfsp_pkg::REG_STAT, sfsp_pkg::RESP_OKAY, d); while (d[0]);
    endtask : frame
    task automatic rdst(output logic [7:0] v);
        logic [31:0] d;
        frame(32'h0000_1005, 32'h0); // 05h, two status bytes clocked in
        rd(sfsp_pkg::REG_STAT, sfsp_pkg::RESP_OKAY, d);
        v = d[15:8];
    endtask : rdst
    task automatic wsr(input logic [7:0] v, input logic [7:0] e);
        frame(32'h0000_0006, 32'h0);
        frame(32'h0000_0101, {v, 24'h0});
        do rdst(s); while (s[0]);
        chk(s[7:2], e[7:2]);
    endtask : wsr
    task automatic t_fresh;
        logic [31:0] d;
        rdst(s); chk(s, 8'h00);
        rd(32'h0000_0010, sfsp_pkg::RESP_SLVERR, d); chk(d, 32'h0);
        frame(32'h0000_0101, 32'hfc00_0000); rdst(s); chk(s, 8'h00);
    endtask : t_fresh
    task automatic t_write;
        frame(32'h0000_0006, 32'h0); rdst(s); chk(s, 8'h02);
        frame(32'h0000_0101, 32'hfc00_0000);
        rdst(s); chk(s, 8'h03);
        do rdst(s); while (s[0]);
        chk(s, 8'h8c);
    endtask : t_write
    task automatic t_lock;
        logic [31:0] d;
        wr(sfsp_pkg::REG_GUARD, 32'h0, sfsp_pkg::RESP_OKAY);
        rd(sfsp_pkg::REG_GUARD, sfsp_pkg::RESP_OKAY, d); chk(d[0], 1'b0);
        wsr(8'h00, 8'h8c);
        wr(sfsp_pkg::REG_GUARD, 32'h1, sfsp_pkg::RESP_OKAY);
        wsr(8'h00, 8'h00);
        frame(32'h0000_0006, 32'h0);
        frame(32'h0000_0201, 32'hfc00_0000); rdst(s); chk(s, 8'h02);
        wr(sfsp_pkg::REG_GUARD, 32'h0, sfsp_pkg::RESP_OKAY);
        wsr(8'h84, 8'h84);
        chk(hl, 1'b1);
        wsr(8'h00, 8'h84);
    endtask : t_lock
    task automatic t_array;
        frame(32'h0000_0006, 32'h0);
        frame(32'h0000_03d8, 32'h0f00_0000); chk(ops, 0);
        frame(32'h0000_03d8, 32'h0100_0000); chk(ops, 1);
        chk({okind, oaddr}, 32'hd801_0000);
        do rdst(s); while (s[0]);
        chk(s[1], 1'b0);
        frame(32'h0000_0006, 32'h0);
        frame(32'h0000_00c7, 32'h0); chk(ops, 1);
        frame(32'h0000_0402, 32'h0e00_00aa); chk(ops, 2);
        chk({okind, oaddr}, 32'h020e_0000);
        chk({hl, sl}, 2'b11);
    endtask : t_array
    task finish_test;
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        #400us;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge i_mclk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_mclk);
        t_fresh();
        t_write();
        t_lock();
        t_array();
        finish_test();
    end
endmodule : tb_top
